// [cab_array_block.sv]
// Configurable embedded RAM block: true dual, pseudo dual and single port
`timescale 1ns/1ps
`default_nettype none
module cab_array_block
	import cab_pkg::*;
#(
	parameter logic [CAB_ARRAY_BITS-1:0] INIT_BITS = '0
)
(
	// System
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Configuration
	input  wire logic [1:0]  mode_in,
	input  wire logic [3:0]  global_clock_set_in,
	input  wire logic        global_reset_in,
	// Port A selection
	input  wire logic [2:0]  a_clk_sel_in,
	input  wire logic        a_clk_inv_in,
	input  wire logic [1:0]  a_en_sel_in,
	input  wire logic        a_en_inv_in,
	input  wire logic        a_rst_inv_in,
	input  wire logic [2:0]  a_width_in,
	input  wire logic        a_out_reg_in,
	input  wire logic        a_addr_reg_in,
	// Port A pins (write side in pseudo dual-port)
	input  wire logic        port_a_clock_in,
	input  wire logic        port_a_clock_enable_in,
	input  wire logic        port_a_reset_in,
	input  wire logic [13:0] a_addr_in,
	input  wire logic [31:0] a_wdata_in,
	input  wire logic        a_cs_in,
	input  wire logic        a_we_in,
	output      logic [31:0] a_rdata_out,
	// Port B selection
	input  wire logic [2:0]  b_clk_sel_in,
	input  wire logic        b_clk_inv_in,
	input  wire logic [1:0]  b_en_sel_in,
	input  wire logic        b_en_inv_in,
	input  wire logic        b_rst_inv_in,
	input  wire logic [2:0]  b_width_in,
	input  wire logic        b_out_reg_in,
	input  wire logic        b_addr_reg_in,
	// Port B pins (read side in pseudo dual-port)
	input  wire logic        port_b_clock_in,
	input  wire logic        port_b_clock_enable_in,
	input  wire logic        port_b_reset_in,
	input  wire logic [13:0] b_addr_in,
	input  wire logic [31:0] b_wdata_in,
	input  wire logic        b_cs_in,
	input  wire logic        b_we_in,
	output      logic [31:0] b_rdata_out
);

	// ****************************************************************
	// Port control
	// ****************************************************************
	cab_port_ctl_if ctl_a ();
	cab_port_ctl_if ctl_b ();

	cab_port_ctl u_ctl_a
	(
		.clk_in              (clk_in),
		.rst_n_in            (rst_n_in),
		.pin_clock_in        (port_a_clock_in),
		.pin_enable_in       (port_a_clock_enable_in),
		.pin_reset_in        (port_a_reset_in),
		.global_clock_set_in (global_clock_set_in),
		.global_reset_in     (global_reset_in),
		.clk_sel_in          (a_clk_sel_in),
		.clk_inv_in          (a_clk_inv_in),
		.en_sel_in           (a_en_sel_in),
		.en_inv_in           (a_en_inv_in),
		.rst_inv_in          (a_rst_inv_in),
		.ctl                 (ctl_a)
	);

	cab_port_ctl u_ctl_b
	(
		.clk_in              (clk_in),
		.rst_n_in            (rst_n_in),
		.pin_clock_in        (port_b_clock_in),
		.pin_enable_in       (port_b_clock_enable_in),
		.pin_reset_in        (port_b_reset_in),
		.global_clock_set_in (global_clock_set_in),
		.global_reset_in     (global_reset_in),
		.clk_sel_in          (b_clk_sel_in),
		.clk_inv_in          (b_clk_inv_in),
		.en_sel_in           (b_en_sel_in),
		.en_inv_in           (b_en_inv_in),
		.rst_inv_in          (b_rst_inv_in),
		.ctl                 (ctl_b)
	);

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	wire cab_mode_t  mode   = cab_mode_t'(mode_in);
	wire logic       is_tdp = (mode == CAB_MODE_TDP);
	wire logic       is_pdp = (mode == CAB_MODE_PDP);
	wire logic       is_sp  = (mode == CAB_MODE_SP);
	wire logic [13:0] lim   = is_tdp ? CAB_LIM_TDP : CAB_LIM_FULL; // see R01

	// Index 0 is port A, index 1 is port B
	logic [1:0]       rst_p;
	logic [1:0]       tick_p;
	logic [1:0]       can_wr;
	logic [1:0]       out_reg;
	logic [1:0]       addr_reg;
	logic [1:0][2:0]  wcode;
	logic [1:0][5:0]  wbits;
	logic [1:0][13:0] addr_raw;
	logic [1:0][13:0] addr_eff;
	logic [1:0][13:0] base;
	logic [1:0][13:0] wbase;
	logic [1:0][31:0] wdata_raw;
	logic [1:0]       cs_raw;
	logic [1:0]       we_raw;

	// Pseudo dual-port and single-port run both sides on one reset
	assign rst_p[0]  = ctl_a.rst; // see R12 see R17
	assign rst_p[1]  = is_tdp ? ctl_b.rst : ctl_a.rst; // see R14
	assign tick_p[0] = ctl_a.tick & ~rst_p[0]; // see R12
	assign tick_p[1] = ctl_b.tick & ~rst_p[1] & ~is_sp; // see R03 see R14
	assign can_wr    = {is_tdp, 1'b1}; // see R02 see R03

	// Read data may be unregistered in every mode
	assign out_reg   = {b_out_reg_in, a_out_reg_in}; // see R07 see R13 see R17
	// Read address bypass only where the read side may be asynchronous
	assign addr_reg[0] = ~is_sp | a_addr_reg_in; // see R07 see R17
	assign addr_reg[1] = ~is_pdp | b_addr_reg_in; // see R13
	assign wcode[0]  = cab_clamp_code(a_width_in, is_tdp); // see R06
	assign wcode[1]  = cab_clamp_code(b_width_in, is_tdp); // see R06
	assign addr_raw  = {b_addr_in, a_addr_in};
	assign wdata_raw = {b_wdata_in, a_wdata_in};
	assign cs_raw    = {b_cs_in, a_cs_in};
	assign we_raw    = {b_we_in, a_we_in};

	// ****************************************************************
	// Per-port registers
	// ****************************************************************
	logic [1:0][13:0] addr_r;
	logic [1:0][31:0] wdata_r;
	logic [1:0]       wr_r;
	logic [1:0][31:0] rdata_r;
	logic [CAB_ARRAY_BITS-1:0] mem_r = INIT_BITS; // see R18

	// Word n sits at bits n*width upward, so mixed widths share one layout
	for (genvar p = 0; p < 2; p++)
	begin : g_port
		assign wbits[p]    = cab_width_bits(wcode[p]);
		assign addr_eff[p] = addr_reg[p] ? addr_r[p] : addr_raw[p];
		assign base[p]     = 14'(addr_eff[p] << wcode[p]) & lim; // see R04 see R05
		// Writes always use the captured address, even with read bypass
		assign wbase[p]    = 14'(addr_r[p] << wcode[p]) & lim; // see R07 see R17
	end

	function automatic logic [31:0] cab_read_slice(
		input logic [CAB_ARRAY_BITS-1:0] m,
		input logic [13:0]               b,
		input logic [5:0]                w);
		logic [31:0] d;
		d = CAB_RDATA_RST;
		for (int i = 0; i < CAB_DATA_W; i++)
			if (6'(i) < w)
				d[i] = m[14'(b + 14'(i))]; // see R04 see R05
		return d;
	endfunction

	// Inputs are captured on the selected port clock edge; the array write
	// follows one system cycle later from the captured values
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			addr_r  <= '0;
			wdata_r <= '0;
			wr_r    <= '0;
			rdata_r <= '0; // see R21
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				wr_r[p] <= tick_p[p] & cs_raw[p] & we_raw[p] & can_wr[p]; // see R07
				if (tick_p[p])
				begin
					addr_r[p]  <= addr_raw[p]; // see R07 see R13
					wdata_r[p] <= wdata_raw[p]; // see R07 see R13
				end
				if (rst_p[p])
					rdata_r[p] <= CAB_RDATA_RST; // see R21
				else if (!out_reg[p] || tick_p[p])
					rdata_r[p] <= cab_read_slice(mem_r, base[p], wbits[p]);
			end
		end
	end

	// ****************************************************************
	// Array
	// ****************************************************************
	// No reset here: contents survive reset. Simultaneous writes to one
	// bit from both ports are not arbitrated; port B lands last.
	always_ff @(posedge clk_in)
	begin
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < CAB_DATA_W; i++)
				if (wr_r[p] && 6'(i) < wbits[p])
					mem_r[14'(wbase[p] + 14'(i))] <= wdata_r[p][i]; // see R09
	end

	// Port reset acts at once on the outputs, without waiting for a clock
	assign a_rdata_out = rdata_r[0] & ~{CAB_DATA_W{rst_p[0]}}; // see R12
	assign b_rdata_out = rdata_r[1] & ~{CAB_DATA_W{rst_p[1]}}; // see R12

endmodule // cab_array_block
`default_nettype wire

// [cab_pkg.sv]
// Constants, types and helper functions of the configurable array block
// ****************************************************************
// Overview of operation
// R01: True dual-port: two read/write ports on 8192 bits, widths 1 to 16.
// R02: Pseudo dual-port: write port and read port on 16384 bits, widths to 32.
// R03: Single-port: one read/write port on 16384 bits, widths 1 to 32.
// R04: Word zero fills lowest bits LSB first, then word one, for any width.
// R05: A wide word reads back as consecutive narrow words on the other port.
// R06: Each port of both dual-port modes has its own data width.
// R07: True dual-port inputs always registered; read data registered optionally.
// R08: Ports independent; each port has one clock, enable and reset choice.
// R09: User logic must never write from both ports at once; no arbitration.
// R10: Dual-port clock is port pin or a global clock, optionally inverted.
// R11: Dual-port enable is port pin or global clock 1 or 2, optionally inverted.
// R12: Port reset is global reset OR optionally inverted port reset, asynchronous.
// R13: Pseudo dual-port write side registered; read data and address optional.
// R14: Write side and read side own clock and enable, but share one reset.
// R15: Write and read clocks from own pin or global clock, optionally inverted.
// R16: Write and read enables from own pin or global clocks, optionally inverted.
// R17: Single-port: one clock, enable, reset; writes registered, reads optional.
// R18: Array contents preset bit by bit at power-on, usable as ROM.
// R19: User logic widens by shared addresses, deepens by muxing read outputs.
// R20: Single-port register clock is port pin or global clock, optionally inverted.
// R21: Reset clears registered read data to zero; array contents survive reset.
// ****************************************************************
package cab_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int          CAB_ARRAY_BITS = 16384;
	localparam int          CAB_ADDR_W     = 14;
	localparam int          CAB_DATA_W     = 32;
	localparam logic [13:0] CAB_LIM_TDP    = 14'h1fff;
	localparam logic [13:0] CAB_LIM_FULL   = 14'h3fff;
	localparam logic [2:0]  CAB_WCODE_TDP  = 3'h4;
	localparam logic [2:0]  CAB_WCODE_MAX  = 3'h5;
	localparam logic [31:0] CAB_RDATA_RST  = 32'h0;
	localparam logic        CAB_PREV_RST   = 1'h0;

	// ****************************************************************
	// Selector codes
	// ****************************************************************
	localparam logic [2:0]  CAB_CLK_PIN    = 3'h0;
	localparam logic [1:0]  CAB_EN_PIN     = 2'h0;
	localparam logic [1:0]  CAB_EN_GLB1    = 2'h1;

	typedef enum logic [1:0]
	{
		CAB_MODE_TDP = 2'b00,
		CAB_MODE_PDP = 2'b01,
		CAB_MODE_SP  = 2'b10
	} cab_mode_t;

	// Width code 0..5 gives 1..32 bits; illegal codes clamp to mode maximum
	function automatic logic [2:0] cab_clamp_code(input logic [2:0] code,
		input logic tdp);
		logic [2:0] lim;
		lim = tdp ? CAB_WCODE_TDP : CAB_WCODE_MAX;
		return (code > lim) ? lim : code;
	endfunction

	function automatic logic [5:0] cab_width_bits(input logic [2:0] code);
		return 6'(6'h1 << code);
	endfunction

endpackage

// [cab_port_ctl_if.sv]
// Clock tick and reset bundle from a port controller to the array core
`timescale 1ns/1ps
`default_nettype none
interface cab_port_ctl_if;
	logic tick;
	logic rst;
	modport src (output tick, output rst);
	modport dst (input tick, input rst);
endinterface
`default_nettype wire

// [cab_port_ctl.sv]
// Per-port clock, clock enable and reset selection
`timescale 1ns/1ps
`default_nettype none
module cab_port_ctl
	import cab_pkg::*;
(
	// System
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Port pins and device-wide lines
	input  wire logic        pin_clock_in,
	input  wire logic        pin_enable_in,
	input  wire logic        pin_reset_in,
	input  wire logic [3:0]  global_clock_set_in,
	input  wire logic        global_reset_in,
	// Selection
	input  wire logic [2:0]  clk_sel_in,
	input  wire logic        clk_inv_in,
	input  wire logic [1:0]  en_sel_in,
	input  wire logic        en_inv_in,
	input  wire logic        rst_inv_in,
	// To array core
	cab_port_ctl_if.src      ctl
);

	// ****************************************************************
	// Selection
	// ****************************************************************
	// Codes above four fall back to the port pin rather than a dead clock
	wire logic [1:0] gsel    = 2'(clk_sel_in - 3'h1);
	wire logic       raw_clk = (clk_sel_in == CAB_CLK_PIN || clk_sel_in > 3'h4)
		? pin_clock_in : global_clock_set_in[gsel]; // see R10 see R15 see R20
	wire logic       sel_clk = raw_clk ^ clk_inv_in; // see R10
	wire logic       raw_en  = (en_sel_in == CAB_EN_PIN) ? pin_enable_in
		: (en_sel_in == CAB_EN_GLB1) ? global_clock_set_in[1]
		: global_clock_set_in[2]; // see R11 see R16
	wire logic       sel_en  = raw_en ^ en_inv_in; // see R11 see R16
	logic            prev_r;

	assign ctl.rst  = global_reset_in | (pin_reset_in ^ rst_inv_in); // see R12
	// Reset gating is left to the core, which knows which reset a side uses
	assign ctl.tick = sel_clk & ~prev_r & sel_en;

	// ****************************************************************
	// Edge detect
	// ****************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			prev_r <= CAB_PREV_RST;
		else
			prev_r <= sel_clk;
	end

endmodule // cab_port_ctl
`default_nettype wire

// [cab_array_block_monitor.sv]
// Port checks of the configurable array block
`timescale 1ns/1ps
`default_nettype none
module cab_array_block_monitor
	import cab_pkg::*;
(
	// System
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [1:0]  mode_in,
	input wire logic        global_reset_in,
	// Port A
	input wire logic [2:0]  a_clk_sel_in,
	input wire logic        a_clk_inv_in,
	input wire logic        a_rst_inv_in,
	input wire logic        a_out_reg_in,
	input wire logic        port_a_clock_in,
	input wire logic        port_a_reset_in,
	input wire logic [31:0] a_rdata_out,
	// Port B
	input wire logic [2:0]  b_clk_sel_in,
	input wire logic        b_clk_inv_in,
	input wire logic        b_rst_inv_in,
	input wire logic        b_out_reg_in,
	input wire logic        port_b_clock_in,
	input wire logic        port_b_reset_in,
	input wire logic [31:0] b_rdata_out
);
	// ****
	// Derived conditions
	// ****
	wire logic tdp = mode_in == CAB_MODE_TDP;
	wire logic a_rst = global_reset_in | (port_a_reset_in ^ a_rst_inv_in);
	wire logic b_own = global_reset_in | (port_b_reset_in ^ b_rst_inv_in);
	wire logic b_rst = tdp ? b_own : a_rst;
	// Pin clock chosen and low: no tick can occur, so registered data holds
	wire logic a_idle = a_out_reg_in && a_clk_sel_in == 3'h0 && !a_clk_inv_in
		&& !port_a_clock_in && !a_rst;
	wire logic b_idle = b_out_reg_in && b_clk_sel_in == 3'h0 && !b_clk_inv_in
		&& !port_b_clock_in && !b_rst;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_clr_a;
		a_rst && a_out_reg_in ##1 !a_rst;
	endsequence
	property p_mask_a; a_rst |-> a_rdata_out == 32'h0; endproperty
	property p_mask_b; tdp && b_own |-> b_rdata_out == 32'h0; endproperty
	property p_share_b; !tdp && a_rst |-> b_rdata_out == 32'h0; endproperty
	property p_glb;
		global_reset_in [*2] |-> a_rdata_out == 32'h0 && b_rdata_out == 32'h0;
	endproperty
	property p_rel;
		!$past(rst_n_in) |-> a_rdata_out == 32'h0 && b_rdata_out == 32'h0;
	endproperty
	property p_hold_a; a_idle |=> a_rst || $stable(a_rdata_out); endproperty
	property p_hold_b; b_idle |=> b_rst || $stable(b_rdata_out); endproperty
	property p_clr_a; s_clr_a |-> a_rdata_out == 32'h0; endproperty
	a_mask_a: assert property (p_mask_a) else $error("A not masked");
	a_mask_b: assert property (p_mask_b) else $error("B not masked");
	a_share_b: assert property (p_share_b) else $error("B reset");
	a_glb: assert property (p_glb) else $error("global reset");
	a_rel: assert property (p_rel) else $error("data after reset");
	a_hold_a: assert property (p_hold_a) else $error("A moved");
	a_hold_b: assert property (p_hold_b) else $error("B moved");
	a_clr_a: assert property (p_clr_a) else $error("A not cleared");
endmodule // cab_array_block_monitor
bind cab_array_block cab_array_block_monitor u_cab_array_block_monitor (.*);
`default_nettype wire

// [cab_user_port.sv]
// User logic model driving one port of the array block
`timescale 1ns/1ps
`default_nettype none
module cab_user_port
(
	// System
	input  wire logic        clk_in,
	// Port pins
	output var  logic        ck_out,
	output var  logic [13:0] addr_out,
	output var  logic [31:0] wdata_out,
	output var  logic        cs_out,
	output var  logic        we_out
);
	initial {ck_out, addr_out, wdata_out, cs_out, we_out} = '0;
	// One pin clock pulse per access, held over the tick edge
	task automatic access(input logic [13:0] ad, input logic [31:0] d,
		input logic w);
		@(posedge clk_in);
		{ck_out, addr_out, wdata_out, cs_out, we_out} <= {1'b1, ad, d, 1'b1, w};
		@(posedge clk_in);
		// Released address and data lines show the inverse, so stale values cannot pass
		{ck_out, addr_out, wdata_out, cs_out, we_out} <= {1'b0, ~ad, ~d, 2'h0};
	endtask
endmodule // cab_user_port
`default_nettype wire

// [tb.sv]
// Self-checking testbench of the configurable array block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cab_pkg::*;
	localparam logic [CAB_ARRAY_BITS-1:0] INIT = CAB_ARRAY_BITS'(32'h89ab_cdef);
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        global_reset_in, a_clk_inv_in, a_en_inv_in, a_rst_inv_in;
	logic        a_out_reg_in, a_addr_reg_in, b_clk_inv_in, b_en_inv_in;
	logic        b_rst_inv_in, b_out_reg_in, b_addr_reg_in;
	logic        port_a_clock_in, port_a_clock_enable_in, port_a_reset_in;
	logic        port_b_clock_in, port_b_clock_enable_in, port_b_reset_in;
	logic        a_cs_in, a_we_in, b_cs_in, b_we_in;
	logic [1:0]  mode_in, a_en_sel_in, b_en_sel_in;
	logic [2:0]  a_clk_sel_in, b_clk_sel_in, a_width_in, b_width_in;
	logic [3:0]  global_clock_set_in;
	logic [13:0] a_addr_in, b_addr_in;
	logic [31:0] a_wdata_in, b_wdata_in, a_rdata_out, b_rdata_out;
	int          errors = 0;
	int          tests_run = 0;
	always #5 clk_in = ~clk_in;
	cab_array_block #(.INIT_BITS(INIT)) u_cab_array_block (.*);
	cab_user_port u_port_a (.clk_in(clk_in), .ck_out(port_a_clock_in),
		.addr_out(a_addr_in), .wdata_out(a_wdata_in), .cs_out(a_cs_in),
		.we_out(a_we_in));
	cab_user_port u_port_b (.clk_in(clk_in), .ck_out(port_b_clock_in),
		.addr_out(b_addr_in), .wdata_out(b_wdata_in), .cs_out(b_cs_in),
		.we_out(b_we_in));
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One port per call, so both ports never write together
	task automatic acc(input logic pb, input logic [13:0] ad,
		input logic [31:0] d, input logic w);
		if (pb)
			u_port_b.access(ad, d, w);
		else
			u_port_a.access(ad, d, w);
	endtask
	task automatic rd(input logic pb, input logic [13:0] ad,
		input logic [31:0] exp);
		acc(pb, ad, 32'h0, 1'b0);
		repeat (3) @(posedge clk_in);
		#1 chk(pb ? b_rdata_out : a_rdata_out, exp);
	endtask
	task automatic close_out;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_init;
		acc(1'b1, 14'h0, 32'h0, 1'b1);
		rd(1'b0, 14'h0, 32'h89ab_cdef);
		@(posedge clk_in);
		a_out_reg_in <= 1'b1;
		acc(1'b0, 14'h0, 32'h0, 1'b0);
		acc(1'b0, 14'h1, 32'h0, 1'b0);
		@(negedge clk_in);
		chk(a_rdata_out, 32'h89ab_cdef);
		@(posedge clk_in);
		{a_out_reg_in, a_addr_reg_in} <= 2'h0;
		// Bypassed read address: data must be taken right after the access
		acc(1'b0, 14'h2, 32'h600d, 1'b1);
		acc(1'b0, 14'h2, 32'h0, 1'b0);
		@(negedge clk_in);
		chk(a_rdata_out, 32'h600d);
	endtask
	task automatic t_tdp;
		@(posedge clk_in);
		mode_in <= CAB_MODE_TDP;
		{a_width_in, b_width_in} <= 6'h23;
		acc(1'b0, 14'h1, 32'hbeef, 1'b1);
		rd(1'b1, 14'h2, 32'hef);
		rd(1'b1, 14'h3, 32'hbe);
		acc(1'b1, 14'h0, 32'h5a, 1'b1);
		rd(1'b0, 14'h0, 32'hcd5a);
		rd(1'b0, 14'h200, 32'hcd5a);
	endtask
	task automatic t_wide;
		// One shared address line on both ports gives one wider word
		fork
			acc(1'b0, 14'h0, 32'h0, 1'b0);
			acc(1'b1, 14'h0, 32'h0, 1'b0);
		join
		repeat (3) @(posedge clk_in);
		#1 chk({b_rdata_out[7:0], a_rdata_out[15:0]}, 32'h5a_cd5a);
	endtask
	task automatic t_ctl;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_in);
			a_clk_sel_in <= (i == 0) ? 3'h1 : 3'h0;
			a_clk_inv_in <= i == 1;
			a_en_inv_in <= i == 2;
			port_a_clock_enable_in <= i != 3;
			b_en_inv_in <= i == 4;
			b_clk_inv_in <= i == 5;
			acc(i > 3, (i > 3) ? 14'h2 : 14'h1, 32'h0, 1'b1);
		end
		@(posedge clk_in);
		b_clk_inv_in <= 1'b0;
		a_en_sel_in <= 2'h1;
		global_clock_set_in <= 4'h2;
		rd(1'b0, 14'h1, 32'hbeef);
		acc(1'b0, 14'h1, 32'h1111, 1'b1);
		rd(1'b0, 14'h1, 32'h1111);
		@(posedge clk_in);
		{a_out_reg_in, a_rst_inv_in, b_rst_inv_in} <= 3'h7;
		@(negedge clk_in);
		chk(a_rdata_out | b_rdata_out, 32'h0);
		@(posedge clk_in);
		{a_rst_inv_in, b_rst_inv_in, port_b_reset_in} <= 3'h1;
		@(negedge clk_in);
		chk(b_rdata_out, 32'h0);
		@(posedge clk_in);
		{port_b_reset_in, global_reset_in, a_out_reg_in} <= 3'h2;
		repeat (2) @(posedge clk_in);
		#1 chk(a_rdata_out | b_rdata_out, 32'h0);
		@(posedge clk_in);
		global_reset_in <= 1'b0;
		rd(1'b0, 14'h1, 32'h1111);
	endtask
	task automatic t_pdp;
		@(posedge clk_in);
		mode_in <= CAB_MODE_PDP;
		a_width_in <= 3'h5;
		acc(1'b0, 14'h1ff, 32'h1234_5678, 1'b1);
		for (int i = 0; i < 4; i++)
			rd(1'b1, 14'h7fc + 14'(i), 32'(8'(32'h1234_5678 >> (8 * i))));
		acc(1'b1, 14'h7fc, 32'h0, 1'b1);
		rd(1'b1, 14'h7fc, 32'h78);
		@(posedge clk_in);
		b_addr_reg_in <= 1'b0;
		acc(1'b1, 14'h7fd, 32'h0, 1'b0);
		@(negedge clk_in);
		chk(b_rdata_out, 32'h56);
		@(posedge clk_in);
		b_out_reg_in <= 1'b1;
		@(posedge clk_in);
		port_a_reset_in <= 1'b1;
		@(negedge clk_in);
		chk(b_rdata_out, 32'h0);
	endtask
	initial
	begin
		{global_reset_in, a_clk_inv_in, a_en_inv_in, a_rst_inv_in, a_out_reg_in,
			b_clk_inv_in, b_en_inv_in, b_rst_inv_in, b_out_reg_in, a_en_sel_in,
			b_en_sel_in, a_clk_sel_in, b_clk_sel_in, global_clock_set_in,
			port_a_reset_in, port_b_reset_in} = '0;
		{a_addr_reg_in, b_addr_reg_in} = 2'h3;
		{port_a_clock_enable_in, port_b_clock_enable_in} = 2'h3;
		mode_in = CAB_MODE_SP;
		{a_width_in, b_width_in} = 6'h2d;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_init();
		t_tdp();
		t_wide();
		t_ctl();
		t_pdp();
		close_out();
	end
	// A hang counts as a mismatch
	initial
	begin
		repeat (5000) @(posedge clk_in);
		errors++;
		close_out();
	end
endmodule // tb
`default_nettype wire
